// ==== aiowf_regs.vh ====
// Constants for the analog I/O word format and configuration block
`ifndef AIOWF_REGS_VH
`define AIOWF_REGS_VH
`define AIOWF_ADDR_W 4
`define AIOWF_OFF_IN0 4'h0
`define AIOWF_OFF_IN1 4'h1
`define AIOWF_OFF_IN2 4'h2
`define AIOWF_OFF_IN3 4'h3
`define AIOWF_OFF_OUT 4'h4
`define AIOWF_OFF_CFG 4'h5
`define AIOWF_OFF_ADC 4'h6
`define AIOWF_ADC_W 12
`define AIOWF_WORD_W 16
`define AIOWF_UNI_SHIFT 3
`define AIOWF_BI_SHIFT 4
`define AIOWF_CFG_POL 0
`define AIOWF_CFG_GAIN_LO 1
`define AIOWF_CFG_GAIN_HI 2
`define AIOWF_CFG_ATT_LO 3
`define AIOWF_CFG_ATT_HI 5
`define AIOWF_GAIN_X1 2'h0
`define AIOWF_GAIN_X10 2'h1
`define AIOWF_GAIN_X100 2'h2
`define AIOWF_GAIN_NONE 2'h3
`define AIOWF_ATT_08 3'h1
`define AIOWF_ATT_04 3'h2
`define AIOWF_ATT_02 3'h4
`define AIOWF_RESET_WORD 16'h0000
`define AIOWF_RESET_DAC 12'h000
`define AIOWF_NUM_CH 4
`define AIOWF_SW_ATT_HI 2
`define AIOWF_SW_ATT_LO 0
`define AIOWF_SW_GAIN_HI 3
`define AIOWF_SW_GAIN_LO 4
`define AIOWF_SW_POL 5
`define AIOWF_SYNC_FILL 2'h3
`endif

// ==== aiowf_word_mem.v ====
// Small register-output memory holding the four formatted input words
`timescale 1ns/1ps
`include "aiowf_regs.vh"
module aiowf_word_mem #(
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter DW = 16
) (
  input wire clock,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ==== aiowf_analog_io_fmt.v ====
// Switch decode, input word formatting and output word truncation
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "aiowf_regs.vh"
module aiowf_analog_io_fmt #(
  parameter NUM_CH = `AIOWF_NUM_CH,
  parameter ADC_W = `AIOWF_ADC_W,
  parameter WORD_W = `AIOWF_WORD_W
) (
  input wire clock,
  input wire rst_n,
  input wire attenSelAClosed,
  input wire attenSelBClosed,
  input wire attenSelCClosed,
  input wire gainSelHiClosed,
  input wire gainSelLoClosed,
  input wire polaritySelClosed,
  input wire adcValid,
  input wire [1:0] adcChannel,
  input wire [ADC_W-1:0] adcData,
  input wire [`AIOWF_ADDR_W-1:0] address,
  input wire [WORD_W-1:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [WORD_W-1:0] readData,
  output reg [ADC_W-1:0] dacCode,
  output reg dacLoad,
  output reg cfgUnipolar,
  output reg [1:0] cfgGain,
  output reg [2:0] cfgAtten,
  output reg cfgValid
);
  // Switch pins are asynchronous: three-stage synchroniser per pin
  reg [5:0] swS1_reg;
  reg [5:0] swS2_reg;
  reg [5:0] swS3_reg;
  reg [5:0] swStable_reg;
  reg [5:0] swStable_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] fill_reg;
  reg [WORD_W-1:0] outWord_reg;
  reg [ADC_W-1:0] lastAdc_reg;
  reg rdSel_reg;
  reg [WORD_W-1:0] rdDirect_reg;
  wire [WORD_W-1:0] memData;
  wire [WORD_W-1:0] fmtWord;
  wire [5:0] swRaw;

  localparam ST_SETTLE = 2'h0;
  localparam ST_LATCH = 2'h1;
  localparam ST_RUN = 2'h2;

  // Closed switch is taken as asserted, pin high when closed
  assign swRaw = {polaritySelClosed, gainSelLoClosed, gainSelHiClosed,
                  attenSelCClosed, attenSelBClosed, attenSelAClosed};

  // Left-justify the converter result; shift depends on polarity
  function [WORD_W-1:0] fmtInput;
    input [ADC_W-1:0] code;
    input unipolar;
    begin
      if (unipolar) begin
        fmtInput = {1'b0, code, 3'h0};
      end else begin
        fmtInput = {code, 4'h0};
      end
    end
  endfunction

  // Gain decode: gain_sel_hi is the first switch, gain_sel_lo the second
  function [1:0] decGain;
    input hi;
    input lo;
    begin
      case ({hi, lo})
        2'h0: decGain = `AIOWF_GAIN_X1;
        2'h1: decGain = `AIOWF_GAIN_X10;
        2'h2: decGain = `AIOWF_GAIN_X100;
        default: decGain = `AIOWF_GAIN_NONE;
      endcase
    end
  endfunction

  always @(posedge clock) begin
    if (!rst_n) begin
      swS1_reg <= 6'h00;
      swS2_reg <= 6'h00;
      swS3_reg <= 6'h00;
      swStable_reg <= 6'h00;
    end else begin
      swS1_reg <= swRaw;
      swS2_reg <= swS1_reg;
      swS3_reg <= swS2_reg;
      swStable_reg <= swStable_next;
    end
  end

  // A change counts once stages two and three agree
  always @* begin
    swStable_next = swStable_reg;
    if (swS2_reg == swS3_reg) begin
      swStable_next = swS3_reg;
    end
  end

  // Settle lets the synchroniser fill before the one-time latch
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_SETTLE: begin
        // Wait for the chain to refill, else reset zeros would be latched
        if (fill_reg == `AIOWF_SYNC_FILL && swS2_reg == swS3_reg) begin
          state_next = ST_LATCH;
        end
      end
      ST_LATCH: state_next = ST_RUN;
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_SETTLE;
    endcase
  end

  // Reset stands for power-up; after the latch switches are ignored
  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_SETTLE;
      fill_reg <= 2'h0;
      cfgUnipolar <= 1'b0;
      cfgGain <= `AIOWF_GAIN_X1;
      cfgAtten <= 3'h0;
      cfgValid <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_SETTLE && fill_reg != `AIOWF_SYNC_FILL) begin
        fill_reg <= fill_reg + 2'h1;
      end
      if (state_reg == ST_LATCH) begin
        cfgUnipolar <= swStable_reg[`AIOWF_SW_POL];
        cfgGain <= decGain(swStable_reg[`AIOWF_SW_GAIN_HI],
                           swStable_reg[`AIOWF_SW_GAIN_LO]);
        // Raw one-hot kept; unlisted mixes pass through unflagged
        cfgAtten <= swStable_reg[`AIOWF_SW_ATT_HI:`AIOWF_SW_ATT_LO];
        cfgValid <= 1'b1;
      end
    end
  end

  // One shared configuration formats every channel
  assign fmtWord = fmtInput(adcData, cfgUnipolar);

  aiowf_word_mem #(
    .DEPTH(NUM_CH),
    .AW(2),
    .DW(WORD_W)
  ) u_words (
    .clock(clock),
    .wrEn(adcValid & cfgValid),
    .wrAddr(adcChannel),
    .wrData(fmtWord),
    .rdAddr(address[1:0]),
    .rdData(memData)
  );

  // Output word write; converter takes only the upper bits
  always @(posedge clock) begin
    if (!rst_n) begin
      outWord_reg <= `AIOWF_RESET_WORD;
      dacCode <= `AIOWF_RESET_DAC;
      dacLoad <= 1'b0;
      lastAdc_reg <= `AIOWF_RESET_DAC;
    end else begin
      dacLoad <= 1'b0;
      if (adcValid) begin
        lastAdc_reg <= adcData;
      end
      if (writeStrobe && address == `AIOWF_OFF_OUT) begin
        outWord_reg <= writeData;
        dacCode <= writeData[WORD_W-1:`AIOWF_BI_SHIFT];
        dacLoad <= 1'b1;
      end
    end
  end

  // Read data valid the cycle after the strobe only
  always @(posedge clock) begin
    if (!rst_n) begin
      rdSel_reg <= 1'b0;
      rdDirect_reg <= `AIOWF_RESET_WORD;
    end else begin
      rdSel_reg <= 1'b0;
      rdDirect_reg <= `AIOWF_RESET_WORD;
      if (readStrobe) begin
        case (address)
          `AIOWF_OFF_IN0, `AIOWF_OFF_IN1, `AIOWF_OFF_IN2, `AIOWF_OFF_IN3: begin
            rdSel_reg <= 1'b1;
          end
          `AIOWF_OFF_OUT: rdDirect_reg <= outWord_reg;
          `AIOWF_OFF_CFG: rdDirect_reg <= {9'h000, cfgValid, cfgAtten, cfgGain,
                                            cfgUnipolar};
          `AIOWF_OFF_ADC: rdDirect_reg <= {4'h0, lastAdc_reg};
          default: rdDirect_reg <= `AIOWF_RESET_WORD;
        endcase
      end
    end
  end

  always @* begin
    readData = rdSel_reg ? memData : rdDirect_reg;
  end
endmodule

// ==== aiowf_props.sv ====
// Checker for switch decode, config readback and output truncation
`timescale 1ns/1ps
module aiowf_props (
  input wire clock, input wire rst_n,
  input wire attenSelAClosed, input wire attenSelBClosed, input wire attenSelCClosed,
  input wire gainSelHiClosed, input wire gainSelLoClosed, input wire polaritySelClosed,
  input wire [3:0] address, input wire [15:0] writeData, input wire writeStrobe,
  input wire readStrobe, input wire [15:0] readData, input wire [11:0] dacCode,
  input wire dacLoad, input wire cfgUnipolar, input wire [1:0] cfgGain,
  input wire [2:0] cfgAtten, input wire cfgValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_out_write;
    writeStrobe && address == 4'h4;
  endsequence
  sequence s_dac_taken;
    dacLoad && dacCode == $past(writeData[15:4]);
  endsequence
  a_dac_upper_bits: assert property (s_out_write |=> s_dac_taken)
    else $error("dac code not upper word bits");
  a_load_needs_write: assert property (dacLoad |-> $past(writeStrobe && address == 4'h4))
    else $error("dac load without write");
  a_cfg_frozen: assert property (cfgValid |=> cfgValid && $stable({cfgUnipolar, cfgGain, cfgAtten}))
    else $error("config changed after latch");
  a_cfg_soon: assert property ($rose(rst_n) |-> ##[3:8] cfgValid)
    else $error("config not latched after power-up");
  a_pol_decode: assert property ($rose(cfgValid) |-> cfgUnipolar == polaritySelClosed)
    else $error("polarity decode wrong");
  a_gain_decode: assert property ($rose(cfgValid) |-> cfgGain == {gainSelHiClosed, gainSelLoClosed})
    else $error("gain decode wrong");
  a_att_decode: assert property ($rose(cfgValid) |->
    cfgAtten == {attenSelCClosed, attenSelBClosed, attenSelAClosed})
    else $error("attenuation decode wrong");
  a_cfg_readback: assert property (readStrobe && address == 4'h5 |=>
    readData == {9'h000, cfgValid, cfgAtten, cfgGain, cfgUnipolar})
    else $error("config readback wrong");
endmodule
bind aiowf_analog_io_fmt aiowf_props aiowf_props_i (.*);

// ==== aiowf_cpu_model.sv ====
// CPU model mastering the register port
`timescale 1ns/1ps
module aiowf_cpu_model (
  input wire clock,
  input wire [15:0] readData,
  output logic [3:0] address = 4'h0,
  output logic [15:0] writeData = 16'h0000,
  output logic writeStrobe = 1'b0,
  output logic readStrobe = 1'b0
);
  // Averaging depth the CPU would set up; the converter model here does not average
  localparam int AvgSamples = 64;
  // Bit 15 carries the sign, passed through untouched
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    writeData <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask
endmodule

// ==== testbench.sv ====
// Bench for switch decode, input words and output word truncation
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] sw = 6'h00;
  logic adcValid = 1'b0;
  logic [1:0] adcChannel = 2'h0;
  logic [11:0] adcData = 12'h000;
  wire [3:0] address;
  wire [15:0] writeData, readData;
  wire writeStrobe, readStrobe, dacLoad, cfgUnipolar, cfgValid;
  wire [11:0] dacCode;
  wire [1:0] cfgGain;
  wire [2:0] cfgAtten;
  int failures = 0;
  int checked = 0;
  logic [15:0] got;
  logic [5:0] setting [4] = '{6'h25, 6'h12, 6'h08, 6'h37};
  logic [11:0] code [4] = '{12'hFFF, 12'h001, 12'h800, 12'h7FF};
  initial forever #20 clock = ~clock;
  aiowf_analog_io_fmt aiowf_analog_io_fmt_i (.clock(clock), .rst_n(rst_n),
    .attenSelAClosed(sw[5]), .attenSelBClosed(sw[4]), .attenSelCClosed(sw[3]),
    .gainSelHiClosed(sw[2]), .gainSelLoClosed(sw[1]), .polaritySelClosed(sw[0]),
    .adcValid(adcValid), .adcChannel(adcChannel), .adcData(adcData), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .dacCode(dacCode), .dacLoad(dacLoad), .cfgUnipolar(cfgUnipolar),
    .cfgGain(cfgGain), .cfgAtten(cfgAtten), .cfgValid(cfgValid));
  aiowf_cpu_model aiowf_cpu_model_i (.clock(clock), .readData(readData), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      rst_n <= 1'b0;
      sw <= setting[s];
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      for (int w = 0; w < 20 && cfgValid !== 1'b1; w++) @(posedge clock);
      if (cfgValid !== 1'b1) begin
        failures++;
        complete_run();
      end
      // Flipping every switch after the latch must change nothing
      sw <= ~setting[s];
      for (int c = 0; c < 4; c++) begin
        @(posedge clock);
        adcValid <= 1'b1;
        adcChannel <= c[1:0];
        adcData <= code[c];
      end
      @(posedge clock);
      adcValid <= 1'b0;
      adcData <= 12'h5A5;
      aiowf_cpu_model_i.rd(4'h5, got);
      chk("config", got, {10'h001, setting[s][3], setting[s][4], setting[s][5],
        setting[s][2:1], setting[s][0]});
      for (int c = 0; c < 4; c++) begin
        aiowf_cpu_model_i.rd(c[3:0], got);
        chk("input word", got, setting[s][0] ? {1'b0, code[c], 3'h0} : {code[c], 4'h0});
      end
      aiowf_cpu_model_i.wr(4'h4, {code[s], 4'hF});
      #1 chk("dac code", {4'h0, dacCode}, {4'h0, code[s]});
      chk("dac load", {15'h0000, dacLoad}, 16'h0001);
      aiowf_cpu_model_i.rd(4'h4, got);
      chk("output word", got, {code[s], 4'hF});
      aiowf_cpu_model_i.rd(4'h6, got);
      chk("last adc", got, {4'h0, code[3]});
      aiowf_cpu_model_i.rd(4'hF, got);
      chk("unmapped read", got, 16'h0000);
      $display("Setting %0d done", s);
    end
    complete_run();
  end
endmodule
